// ### logic/pfmux_top.sv
// pin function mux with input-source selectors and keyed port read-back
// Function
// [R1] port c upper select keeps four low bits; upper bits read zero
// [R2] pc5/pc4 fields: 00 plain io, 01 phase c low/high gate
// [R3] software sets all port c fields to 01 for gate-driver link
// [R4] pd3 and pd2 field codes pick io, timer1, hall, phase a gates
// [R5] pd1 field codes pick io, timer0, hall c, uart; pd0 codes pick io, tmr0_out_inv, tmr0_out, uart
// [R6] pd7 field: io, tmr3_out, tmr0_out_inv, phase_c_low_gate
// [R7] small packages keep pd7 field at 00 from power-on
// [R8] pd6..pd4 fields pick io, analog/timers, phase gates
// [R9] hall inputs pick port a or b pins per two-bit code
// [R10] aux trigger and external irq sources chosen by two-bit fields
// [R11] single bits pick i2c data and clock input pins
// [R12] uart and noise filter input sources per two-bit code
// [R13] small packages never choose code 11 for noise filter source
// [R14] timer capture inputs pick port a/b or port d pins
// [R15] small packages never choose code 10 for tmr0 capture source
// [R16] timer clock inputs pick port a/b or port d pins
// [R17] small packages never choose code 10 for tmr0 clock source
// [R18] read-back flag set only while key register holds 0xca
// [R19] read-back on: port reads return live pin levels
// [R20] read-back off: latch path, pins follow selected function
// [R21] read-back touches only the read path, never the mux
// [R22] analog switch closes when selected and function on, or read-back
`timescale 1ns/1ps
`default_nettype none
module pfmux_top (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [5:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [5:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    input wire logic [7:0] i_pa_pin,
    input wire logic [7:0] i_pb_pin,
    input wire logic [7:0] i_pd_pin,
    input wire logic [7:0] i_pd_latch,
    input wire logic [7:0] i_pd_dir_in,
    input wire pfmux_pkg::pfmux_periph_t i_periph,
    input wire logic [3:0] i_adc_ch_sel,
    output logic [5:4] o_pc_gate_sel,
    output logic [7:0] o_pd_out,
    output logic [7:0] o_pd_fn_oe,
    output pfmux_pkg::pfmux_route_t o_route,
    output logic [7:0] o_pd_read,
    output logic o_analog_sw_on,
    output logic o_readback_mode_flag
);
    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    logic [23:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_r;
    // three stages; a level is taken only once stage two and three agree
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            pin_s3_r <= '0;
            pin_r <= '0;
        end else begin
            pin_s1_r <= {i_pd_pin, i_pb_pin, i_pa_pin};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            for (int k = 0; k < 24; k++) begin
                if (pin_s2_r[k] == pin_s3_r[k]) pin_r[k] <= pin_s3_r[k];
            end
        end
    end
    logic [7:0] pa, pb, pd;
    assign pa = pin_r[7:0];
    assign pb = pin_r[15:8];
    assign pd = pin_r[23:16];

    // ****************************************************************
    // registers and axi4-lite slave
    // ****************************************************************
    logic [7:0] pc_hi_r, pd_lo_r, pd_hi_r, hall_r, serial_r, cap_r, clk_r, key_r;
    logic [5:0] awaddr_r;
    logic aw_held_r, w_held_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic do_write;

    // address and data may come in either order; both are held until used
    assign o_awready = !aw_held_r && !o_bvalid;
    assign o_wready = !w_held_r && !o_bvalid;
    assign do_write = aw_held_r && w_held_r && !o_bvalid;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r <= i_awaddr;
            end else if (do_write) begin
                aw_held_r <= 1'b0;
            end
            if (i_wvalid && o_wready) begin
                w_held_r <= 1'b1;
                wdata_r <= i_wdata;
                wstrb_r <= i_wstrb;
            end else if (do_write) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // decode shared by write and read sides
    function automatic logic addr_hit(input logic [5:0] a);
        case (a)
            pfmux_pkg::ADDR_PORTC_HI, pfmux_pkg::ADDR_PORTD_LO, pfmux_pkg::ADDR_PORTD_HI,
            pfmux_pkg::ADDR_HALL_TRIG, pfmux_pkg::ADDR_SERIAL_IRQ, pfmux_pkg::ADDR_CAPTURE,
            pfmux_pkg::ADDR_TMR_CLK, pfmux_pkg::ADDR_RB_KEY,
            pfmux_pkg::ADDR_STATUS: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    endfunction

    logic wr_lane;
    assign wr_lane = do_write && wstrb_r[0];

    // register writes; only byte lane 0 carries data
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            pc_hi_r <= pfmux_pkg::RESET_VAL;
            pd_lo_r <= pfmux_pkg::RESET_VAL;
            pd_hi_r <= pfmux_pkg::RESET_VAL;
            hall_r <= pfmux_pkg::RESET_VAL;
            serial_r <= pfmux_pkg::RESET_VAL;
            cap_r <= pfmux_pkg::RESET_VAL;
            clk_r <= pfmux_pkg::RESET_VAL;
            key_r <= pfmux_pkg::RESET_VAL; // [R18]
        end else if (wr_lane) begin
            case (awaddr_r)
                pfmux_pkg::ADDR_PORTC_HI: pc_hi_r <= wdata_r[7:0] & pfmux_pkg::PORTC_HI_MASK; // [R1]
                pfmux_pkg::ADDR_PORTD_LO: pd_lo_r <= wdata_r[7:0];
                pfmux_pkg::ADDR_PORTD_HI: pd_hi_r <= wdata_r[7:0];
                pfmux_pkg::ADDR_HALL_TRIG: hall_r <= wdata_r[7:0];
                pfmux_pkg::ADDR_SERIAL_IRQ: serial_r <= wdata_r[7:0];
                pfmux_pkg::ADDR_CAPTURE: cap_r <= wdata_r[7:0];
                pfmux_pkg::ADDR_TMR_CLK: clk_r <= wdata_r[7:0];
                pfmux_pkg::ADDR_RB_KEY: key_r <= wdata_r[7:0]; // [R18]
                default: ;
            endcase
        end
    end

    // write response: one cycle after both halves are present
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_bvalid <= 1'b0;
            o_bresp <= pfmux_pkg::RESP_OKAY;
        end else if (do_write) begin
            o_bvalid <= 1'b1;
            o_bresp <= addr_hit(awaddr_r) ? pfmux_pkg::RESP_OKAY : pfmux_pkg::RESP_SLVERR;
        end else if (i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    // read side: flag lives in bit 0 of the status word
    logic [7:0] rd_val;
    always_comb begin
        case (i_araddr)
            pfmux_pkg::ADDR_PORTC_HI: rd_val = pc_hi_r;
            pfmux_pkg::ADDR_PORTD_LO: rd_val = pd_lo_r;
            pfmux_pkg::ADDR_PORTD_HI: rd_val = pd_hi_r;
            pfmux_pkg::ADDR_HALL_TRIG: rd_val = hall_r;
            pfmux_pkg::ADDR_SERIAL_IRQ: rd_val = serial_r;
            pfmux_pkg::ADDR_CAPTURE: rd_val = cap_r;
            pfmux_pkg::ADDR_TMR_CLK: rd_val = clk_r;
            pfmux_pkg::ADDR_RB_KEY: rd_val = key_r;
            pfmux_pkg::ADDR_STATUS: rd_val = {7'h00, o_readback_mode_flag};
            default: rd_val = 8'h00;
        endcase
    end
    assign o_arready = !o_rvalid;
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_rvalid <= 1'b0;
            o_rdata <= '0;
            o_rresp <= pfmux_pkg::RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            o_rvalid <= 1'b1;
            o_rdata <= {24'h000000, rd_val};
            o_rresp <= addr_hit(i_araddr) ? pfmux_pkg::RESP_OKAY : pfmux_pkg::RESP_SLVERR;
        end else if (i_rready) begin
            o_rvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // read-back mode
    // ****************************************************************
    // flag is a pure decode of the key, so writing any other value to the key register clears it
    assign o_readback_mode_flag = (key_r == pfmux_pkg::READBACK_KEY); // [R18]

    // ****************************************************************
    // output function mux
    // ****************************************************************
    // picks one of four sources by a two-bit code
    function automatic logic pick4(input logic [1:0] s, input logic [3:0] v);
        pick4 = v[s];
    endfunction

    logic [15:0] pd_sel;
    assign pd_sel = {pd_hi_r, pd_lo_r};
    pfmux_pkg::pfmux_periph_t p;
    assign p = i_periph;

    // per pin: drive value and whether a peripheral owns the pin
    logic [7:0] pd_fn_val;
    logic [7:0] pd_fn_own;
    always_comb begin
        pd_fn_val = 8'h00;
        pd_fn_own = 8'h00;
        // code order per pin is {11,10,01,00}
        pd_fn_val[3] = pick4(pd_sel[7:6], {p.phase_a_low_gate, p.hall_a_out,
            p.tmr1_out, 1'b0}); // [R4]
        pd_fn_val[2] = pick4(pd_sel[5:4], {p.phase_a_high_gate, p.hall_b_out,
            p.tmr1_out_inv, 1'b0}); // [R4]
        pd_fn_val[1] = pick4(pd_sel[3:2], {p.uart_tx, p.hall_c_out,
            p.tmr0_out, 1'b0}); // [R5]
        pd_fn_val[0] = pick4(pd_sel[1:0], {p.uart_tx, p.tmr0_out,
            p.tmr0_out_inv, 1'b0}); // [R5]
        pd_fn_val[7] = pick4(pd_sel[15:14], {p.phase_c_low_gate, p.tmr0_out_inv,
            p.tmr3_out, 1'b0}); // [R6] [R7]
        pd_fn_val[6] = pick4(pd_sel[13:12], {p.phase_c_high_gate, p.tmr0_out,
            1'b0, 1'b0}); // [R8]
        pd_fn_val[5] = pick4(pd_sel[11:10], {p.phase_b_low_gate, p.tmr1_out_inv,
            p.tmr2_out, 1'b0}); // [R8]
        pd_fn_val[4] = pick4(pd_sel[9:8], {p.phase_b_high_gate, p.tmr1_out,
            p.tmr2_out_inv, 1'b0}); // [R8]
        for (int k = 0; k < 8; k++) begin
            pd_fn_own[k] = (pd_sel[2*k +: 2] != pfmux_pkg::SEL_0);
        end
        // analog code on pd6 drives nothing and leaves the pin unowned
        if (pd_sel[13:12] == pfmux_pkg::SEL_1) pd_fn_own[6] = 1'b0;
        // uart on pd1 is two-way; the uart decides when it drives
        if (pd_sel[3:2] == pfmux_pkg::SEL_3) pd_fn_own[1] = p.uart_oe;
    end

    // registered outputs; untouched by the read-back flag
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_pd_out <= '0;
            o_pd_fn_oe <= '0;
            o_pc_gate_sel <= '0;
        end else begin
            o_pd_out <= pd_fn_val; // [R21]
            o_pd_fn_oe <= pd_fn_own;
            o_pc_gate_sel[5] <= (pc_hi_r[3:2] == pfmux_pkg::SEL_1); // [R2] [R3]
            o_pc_gate_sel[4] <= (pc_hi_r[1:0] == pfmux_pkg::SEL_1); // [R2]
        end
    end

    // ****************************************************************
    // input source selectors
    // ****************************************************************
    pfmux_pkg::pfmux_route_t rt;
    always_comb begin
        rt = '0;
        rt.hall_in[3] = pick4(hall_r[7:6], {pa[5], pb[5], pb[1], pa[5]}); // [R9]
        rt.hall_in[2] = pick4(hall_r[5:4], {pa[4], pb[6], pb[2], pa[4]}); // [R9]
        rt.hall_in[1] = pick4(hall_r[3:2], {pa[3], pb[7], pb[3], pa[3]}); // [R9]
        rt.aux_trigger_in = pick4(hall_r[1:0], {pd[6], pd[0], pb[4], pa[6]}); // [R10]
        rt.ext_irq_in = pick4(serial_r[1:0], {pd[5], pa[2], pd[1], pa[7]}); // [R10]
        rt.i2c_sda_in = serial_r[7] ? pb[7] : pa[7]; // [R11]
        rt.i2c_scl_in = serial_r[6] ? pb[5] : pb[0]; // [R11]
        rt.uart_rx_in = pick4(serial_r[5:4], {pb[4], pa[7], pd[1], pb[7]}); // [R12]
        rt.noise_filter_in = pick4(serial_r[3:2], {pd[7], pd[2], pa[0], pa[7]}); // [R12] [R13]
        rt.tmr_cap_in[0] = pick4(cap_r[7:6], {pa[0], pd[7], pd[3], pa[0]}); // [R14] [R15]
        rt.tmr_cap_in[1] = pick4(cap_r[5:4], {pa[2], pd[6], pd[2], pa[2]}); // [R14]
        rt.tmr_cap_in[2] = pick4(cap_r[3:2], {pb[2], pd[5], pd[1], pb[2]}); // [R14]
        rt.tmr_cap_in[3] = pick4(cap_r[1:0], {pb[1], pd[4], pd[0], pb[1]}); // [R14]
        rt.tmr_clk_in[0] = pick4(clk_r[7:6], {pb[6], pd[7], pd[3], pa[7]}); // [R16] [R17]
        rt.tmr_clk_in[1] = pick4(clk_r[5:4], {pa[6], pd[6], pd[2], pa[6]}); // [R16]
        rt.tmr_clk_in[2] = pick4(clk_r[3:2], {pb[3], pd[5], pd[1], pb[3]}); // [R16]
        rt.tmr_clk_in[3] = pick4(clk_r[1:0], {pb[0], pd[4], pd[0], pb[0]}); // [R16]
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) o_route <= '0;
        else o_route <= rt;
    end

    // ****************************************************************
    // port read path and analog switch
    // ****************************************************************
    // read-back: live pin; else any input gives pin, io outputs give latch,
    // peripheral and analog codes on outputs give zero, uart on pd1 gives pin
    // zero follows the field code, not the drive enable, so analog reads 0
    logic [7:0] rd_nxt;
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            if (o_readback_mode_flag) rd_nxt[k] = pd[k]; // [R19]
            else if (i_pd_dir_in[k]) rd_nxt[k] = pd[k]; // [R20]
            else if (pd_sel[2*k +: 2] != pfmux_pkg::SEL_0) rd_nxt[k] = 1'b0; // [R20]
            else rd_nxt[k] = i_pd_latch[k]; // [R20]
        end
        if (!o_readback_mode_flag && !i_pd_dir_in[1]
                && pd_sel[3:2] == pfmux_pkg::SEL_3) rd_nxt[1] = pd[1];
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) o_pd_read <= '0;
        else o_pd_read <= rd_nxt;
    end

    logic analog_ch10_fn;
    assign analog_ch10_fn = (pd_sel[13:12] == pfmux_pkg::SEL_1);
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) o_analog_sw_on <= 1'b0;
        else o_analog_sw_on <= (i_adc_ch_sel == 4'(pfmux_pkg::ANALOG_CH10))
            && (analog_ch10_fn || o_readback_mode_flag); // [R22]
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    pc_hi_upper_a: assert property (pc_hi_r[7:4] == 4'h0) // [R1]
        else $error("port c upper bits not zero");
    key_flag_a: assert property (wr_lane && awaddr_r == pfmux_pkg::ADDR_RB_KEY // [R18]
        |=> o_readback_mode_flag == ($past(wdata_r[7:0]) == pfmux_pkg::READBACK_KEY))
        else $error("read-back flag disagrees with key");
    pc5_gate_a: assert property (pc_hi_r[3:2] == 2'h1 |=> o_pc_gate_sel[5]) // [R2]
        else $error("pc5 gate select missing");
    pd7_fn_a: assert property (pd_sel[15:14] == 2'h2 // [R6]
        |=> o_pd_out[7] == $past(p.tmr0_out_inv))
        else $error("pd7 tmr0_out_inv not routed");
    pd3_gate_a: assert property (pd_sel[7:6] == 2'h3 // [R4]
        |=> o_pd_out[3] == $past(p.phase_a_low_gate))
        else $error("pd3 gate not routed");
    rb_read_a: assert property (o_readback_mode_flag |=> o_pd_read == $past(pd)) // [R19]
        else $error("read-back did not return pins");
    latch_read_a: assert property (!o_readback_mode_flag && i_pd_dir_in == 8'h00 // [R20]
        && pd_sel == 16'h0000 |=> o_pd_read == $past(i_pd_latch))
        else $error("latch path not used");
    an_read_a: assert property (!o_readback_mode_flag && !i_pd_dir_in[6] && analog_ch10_fn // [R20]
        |=> !o_pd_read[6])
        else $error("analog pin read not zero");
    analog_sw_a: assert property (o_readback_mode_flag // [R22]
        && i_adc_ch_sel == 4'(pfmux_pkg::ANALOG_CH10) |=> o_analog_sw_on)
        else $error("analog switch not forced");
    sda_route_a: assert property (serial_r[7] |=> o_route.i2c_sda_in == $past(pb[7])) // [R11]
        else $error("sda source wrong");
    rb_mux_a: assert property ($rose(o_readback_mode_flag) && $stable(pd_sel) // [R21]
        && $stable(p.uart_oe) |=> $stable(o_pd_fn_oe))
        else $error("read-back changed mux");
    cov_rb_c: cover property ($rose(o_readback_mode_flag));
    cov_wr_c: cover property (do_write ##1 o_bvalid);
    cov_an_c: cover property (analog_ch10_fn ##1 o_analog_sw_on);
    cov_uart_c: cover property (pd_sel[3:2] == pfmux_pkg::SEL_3 ##1 o_pd_fn_oe[1]);
endmodule
`default_nettype wire

// ### shared/pfmux_pkg.sv
// package: register map, field codes and carriers for the pin function mux
package pfmux_pkg;
    // register byte addresses on the axi4-lite slave
    localparam logic [5:0] ADDR_PORTC_HI = 6'h00;
    localparam logic [5:0] ADDR_PORTD_LO = 6'h04;
    localparam logic [5:0] ADDR_PORTD_HI = 6'h08;
    localparam logic [5:0] ADDR_HALL_TRIG = 6'h0c;
    localparam logic [5:0] ADDR_SERIAL_IRQ = 6'h10;
    localparam logic [5:0] ADDR_CAPTURE = 6'h14;
    localparam logic [5:0] ADDR_TMR_CLK = 6'h18;
    localparam logic [5:0] ADDR_RB_KEY = 6'h1c;
    localparam logic [5:0] ADDR_STATUS = 6'h20;
    localparam logic [7:0] RESET_VAL = 8'h00;
    localparam logic [7:0] PORTC_HI_MASK = 8'h0f;
    localparam logic [7:0] READBACK_KEY = 8'hca;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // two-bit field codes
    localparam logic [1:0] SEL_0 = 2'h0;
    localparam logic [1:0] SEL_1 = 2'h1;
    localparam logic [1:0] SEL_2 = 2'h2;
    localparam logic [1:0] SEL_3 = 2'h3;
    localparam int ANALOG_CH10 = 10;

    // outputs each port d pin can carry
    typedef struct packed {
        logic tmr0_out;
        logic tmr0_out_inv;
        logic tmr1_out;
        logic tmr1_out_inv;
        logic tmr2_out;
        logic tmr2_out_inv;
        logic tmr3_out;
        logic hall_a_out;
        logic hall_b_out;
        logic hall_c_out;
        logic uart_tx;
        logic uart_oe;
        logic phase_a_high_gate;
        logic phase_a_low_gate;
        logic phase_b_high_gate;
        logic phase_b_low_gate;
        logic phase_c_high_gate;
        logic phase_c_low_gate;
    } pfmux_periph_t;

    // routed peripheral inputs
    typedef struct packed {
        logic [3:1] hall_in;
        logic aux_trigger_in;
        logic ext_irq_in;
        logic i2c_sda_in;
        logic i2c_scl_in;
        logic uart_rx_in;
        logic noise_filter_in;
        logic [3:0] tmr_cap_in;
        logic [3:0] tmr_clk_in;
    } pfmux_route_t;
endpackage

// ### tb/pfmux_far.sv
// far-side model: raw pin levels and peripheral output levels
`timescale 1ns/1ps
`default_nettype none
module pfmux_far (
    input wire logic i_clk,
    input wire logic i_new,
    output logic [7:0] o_pa,
    output logic [7:0] o_pb,
    output logic [7:0] o_pd,
    output pfmux_pkg::pfmux_periph_t o_periph
);
    // ************************************
    // pin and peripheral levels
    // ************************************
    // known levels from time zero so the synchronisers never see x;
    // new levels only on request, then held so the synchronisers settle
    initial begin
        o_pa = 8'h00;
        o_pb = 8'h00;
        o_pd = 8'h00;
        o_periph = '0;
        forever begin
            @(posedge i_clk);
            if (i_new) begin
                o_pa <= 8'($urandom);
                o_pb <= 8'($urandom);
                o_pd <= 8'($urandom);
                o_periph <= 18'($urandom);
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/tb.sv
// testbench: register bus, pin routing and read-back against a behavioural model
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ************************************
    // signals and instances
    // ************************************
    logic clk, rst_b, new_lvl, awvalid, wvalid, bready, arvalid, rready;
    logic [5:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, adc;
    logic [7:0] latch, dir, pa, pb, pd, pdo, pdr, oe;
    pfmux_pkg::pfmux_periph_t per;
    pfmux_pkg::pfmux_route_t rt;
    logic awready, wready, bvalid, arready, rvalid, asw, flag;
    logic [1:0] bresp, rresp;
    logic [5:4] pcg;
    int miscompares, checks;

    pfmux_top dut (.i_clk(clk), .i_rst_b(rst_b), .i_awaddr(awaddr), .i_awvalid(awvalid),
        .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
        .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
        .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
        .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_pa_pin(pa), .i_pb_pin(pb),
        .i_pd_pin(pd), .i_pd_latch(latch), .i_pd_dir_in(dir), .i_periph(per),
        .i_adc_ch_sel(adc), .o_pc_gate_sel(pcg), .o_pd_out(pdo), .o_pd_fn_oe(oe),
        .o_route(rt), .o_pd_read(pdr), .o_analog_sw_on(asw), .o_readback_mode_flag(flag));
    pfmux_far far (.i_clk(clk), .i_new(new_lvl), .o_pa(pa), .o_pb(pb), .o_pd(pd),
        .o_periph(per));

    // ************************************
    // helpers
    // ************************************
    task automatic give_verdict();
        if (miscompares == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // write: address and data offered together, each dropped once taken
    task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [3:0] s,
        input logic [1:0] er);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        bready <= 1'b0;
        if (n >= 50) miscompares++;
        chk(32'(bresp), 32'(er));
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] exp, input logic [1:0] er);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        rready <= 1'b0;
        if (n >= 50) miscompares++;
        chk(rdata, exp);
        chk(32'(rresp), 32'(er));
    endtask

    function automatic logic pk(input logic [3:0] t, input logic [1:0] c);
        return t[c];
    endfunction

    // per-pin output table, index is the pin number, bit position is the field code
    function automatic logic [3:0] t_out(input int i, input pfmux_pkg::pfmux_periph_t p);
        case (i)
            0: return {p.uart_tx, p.tmr0_out, p.tmr0_out_inv, 1'b0};
            1: return {p.uart_tx, p.hall_c_out, p.tmr0_out, 1'b0};
            2: return {p.phase_a_high_gate, p.hall_b_out, p.tmr1_out_inv, 1'b0};
            3: return {p.phase_a_low_gate, p.hall_a_out, p.tmr1_out, 1'b0};
            4: return {p.phase_b_high_gate, p.tmr1_out, p.tmr2_out_inv, 1'b0};
            5: return {p.phase_b_low_gate, p.tmr1_out_inv, p.tmr2_out, 1'b0};
            6: return {p.phase_c_high_gate, p.tmr0_out, 1'b0, 1'b0};
            default: return {p.phase_c_low_gate, p.tmr0_out_inv, p.tmr3_out, 1'b0};
        endcase
    endfunction

    // program all selectors, move the pins, then compare every result
    task automatic step(input logic [7:0] v [8]);
        logic [15:0] fs;
        logic fl;
        logic [7:0] eo, er, ee;
        logic [1:0] c;
        pfmux_pkg::pfmux_route_t e;
        fs = {v[2], v[1]};
        fl = (v[7] == pfmux_pkg::READBACK_KEY);
        for (int k = 0; k < 8; k++) wr(6'(4 * k), v[k], 4'hf, pfmux_pkg::RESP_OKAY);
        @(posedge clk);
        new_lvl <= 1'b1;
        latch <= 8'($urandom);
        dir <= 8'($urandom);
        adc <= ($urandom % 2) ? 4'ha : 4'($urandom);
        @(posedge clk);
        new_lvl <= 1'b0;
        // pins need the synchroniser lag plus the output register
        repeat (8) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            c = fs[2 * i +: 2];
            eo[i] = pk(t_out(i, per), c);
            er[i] = (fl || dir[i] || (i == 1 && c == 2'h3)) ? pd[i] : (c == 2'h0 && latch[i]);
            // analog code drives nothing; uart on pd1 drives when the uart says so
            ee[i] = (i == 1 && c == 2'h3) ? per.uart_oe
                : (c != 2'h0 && !(i == 6 && c == 2'h1));
        end
        e.hall_in[3] = pk({pa[5], pb[5], pb[1], pa[5]}, v[3][7:6]);
        e.hall_in[2] = pk({pa[4], pb[6], pb[2], pa[4]}, v[3][5:4]);
        e.hall_in[1] = pk({pa[3], pb[7], pb[3], pa[3]}, v[3][3:2]);
        e.aux_trigger_in = pk({pd[6], pd[0], pb[4], pa[6]}, v[3][1:0]);
        e.i2c_sda_in = v[4][7] ? pb[7] : pa[7];
        e.i2c_scl_in = v[4][6] ? pb[5] : pb[0];
        e.uart_rx_in = pk({pb[4], pa[7], pd[1], pb[7]}, v[4][5:4]);
        e.noise_filter_in = pk({pd[7], pd[2], pa[0], pa[7]}, v[4][3:2]);
        e.ext_irq_in = pk({pd[5], pa[2], pd[1], pa[7]}, v[4][1:0]);
        e.tmr_cap_in = {pk({pb[1], pd[4], pd[0], pb[1]}, v[5][1:0]),
            pk({pb[2], pd[5], pd[1], pb[2]}, v[5][3:2]),
            pk({pa[2], pd[6], pd[2], pa[2]}, v[5][5:4]),
            pk({pa[0], pd[7], pd[3], pa[0]}, v[5][7:6])};
        e.tmr_clk_in = {pk({pb[0], pd[4], pd[0], pb[0]}, v[6][1:0]),
            pk({pb[3], pd[5], pd[1], pb[3]}, v[6][3:2]),
            pk({pa[6], pd[6], pd[2], pa[6]}, v[6][5:4]),
            pk({pb[6], pd[7], pd[3], pa[7]}, v[6][7:6])};
        chk(32'(pcg), 32'({v[0][3:2] == 2'h1, v[0][1:0] == 2'h1}));
        chk(32'(pdo), 32'(eo));
        chk(32'(oe), 32'(ee));
        chk(32'(rt), 32'(e));
        chk(32'(pdr), 32'(er));
        chk(32'(asw), 32'(int'(adc) == pfmux_pkg::ANALOG_CH10 && (fs[13:12] == 2'h1 || fl)));
        chk(32'(flag), 32'(fl));
        for (int k = 0; k < 8; k++) begin
            rd(6'(4 * k), 32'(k == 0 ? v[0] & pfmux_pkg::PORTC_HI_MASK : v[k]), 2'h0);
        end
        rd(pfmux_pkg::ADDR_STATUS, 32'(fl), pfmux_pkg::RESP_OKAY);
    endtask

    // ************************************
    // clock, sequence and watchdog
    // ************************************
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // cut a hang well past the expected few thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        give_verdict();
    end

    initial begin
        logic [7:0] v [8];
        {rst_b, new_lvl, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
        {awaddr, araddr, wdata, wstrb, adc, latch, dir} = '0;
        miscompares = 0;
        checks = 0;
        void'($urandom(32'h7001));
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        for (int k = 0; k < 9; k++) rd(6'(4 * k), 32'h0, pfmux_pkg::RESP_OKAY);
        rd(6'h24, 32'h0, pfmux_pkg::RESP_SLVERR);
        wr(6'h24, 8'hff, 4'hf, pfmux_pkg::RESP_SLVERR);
        // a write without the low byte lane must leave the register alone
        wr(pfmux_pkg::ADDR_PORTC_HI, 8'hff, 4'he, pfmux_pkg::RESP_OKAY);
        rd(pfmux_pkg::ADDR_PORTC_HI, 32'h0, pfmux_pkg::RESP_OKAY);
        repeat (40) begin
            foreach (v[k]) v[k] = 8'($urandom);
            if ($urandom % 2) v[7] = pfmux_pkg::READBACK_KEY;
            step(v);
        end
        // gate-driver-safe setup as software must leave it
        v = '{8'h05, 8'h00, 8'h3f, 8'h00, 8'h04, 8'h00, 8'h40, 8'hca};
        step(v);
        give_verdict();
    end
endmodule
`default_nettype wire
